// ===== logic/seeb_regs.svh
/*
 * Constants of the serial EEPROM bus front end: timing, geometry, field positions.
 * Assumes the system clock runs at 50 MHz; included by bare name.
 */
`ifndef SEEB_REGS_SVH
`define SEEB_REGS_SVH

// ----------------------------------------------------------------
// timing
// ----------------------------------------------------------------
`define SEEB_CLK_PERIOD_NS 20
`define SEEB_T_WR_MAX_NS 5000000
// longest time: rounded down to whole cycles
`define SEEB_WR_CYCLES (`SEEB_T_WR_MAX_NS / `SEEB_CLK_PERIOD_NS)
`define SEEB_FILT_CYCLES 3

// ----------------------------------------------------------------
// geometry and field positions
// ----------------------------------------------------------------
`define SEEB_ADDR_W 16
`define SEEB_PAGE_BYTES 128
`define SEEB_PAGE_W 7
`define SEEB_TYPE_MSB 7
`define SEEB_TYPE_LSB 4
`define SEEB_STRAP_MSB 3
`define SEEB_STRAP_LSB 1
`define SEEB_RW_BIT 0
// arbitrary neutral type code, not taken from any part
`define SEEB_TYPE_CODE 4'h5

`endif

// ===== logic/seeb_pkg.sv
/*
 * Types of the serial EEPROM bus front end.
 * Assumes nothing of its surroundings.
 */
package seeb_pkg;

    typedef enum logic [2:0] {
        seeb_st_idle = 3'b000,
        seeb_st_dev = 3'b001,
        seeb_st_ahi = 3'b010,
        seeb_st_alo = 3'b011,
        seeb_st_wdat = 3'b100,
        seeb_st_rdat = 3'b101,
        seeb_st_ign = 3'b110
    } seeb_state_t;

endpackage : seeb_pkg

// ===== logic/seeb_filter.sv
/*
 * Two-flop synchroniser followed by a stability filter for one bus pin.
 * Assumes the pin is asynchronous to clk_sys; output idles high (pulled-up bus).
 */
`timescale 1ns/10ps

module seeb_filter #(
    parameter int FILT = 3
) (
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic pin_in,
    output logic pin_out
);
    logic meta_q;
    logic sync_q;
    logic [3:0] stab_cnt_q;

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            meta_q <= 1'b1;
            sync_q <= 1'b1;
        end else begin
            meta_q <= pin_in;
            sync_q <= meta_q;
        end
    end

    // a new level is taken only after it held for FILT samples; shorter spikes vanish
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            stab_cnt_q <= 4'h0;
            pin_out <= 1'b1;
        end else if (sync_q == pin_out) begin
            stab_cnt_q <= 4'h0;
        end else if (stab_cnt_q == 4'(FILT - 1)) begin
            stab_cnt_q <= 4'h0;
            pin_out <= sync_q;
        end else begin
            stab_cnt_q <= stab_cnt_q + 4'h1;
        end
    end

endmodule : seeb_filter

// ===== logic/seeb_front_end.sv
/*
 * Two-wire bus target front end of a 64K x 8 serial EEPROM with its array.
 * Assumes SCL/SDA and straps arrive asynchronously; SDA is open drain with a pull-up.
 */
// Summary of operation
// - start is SDA falling with SCL high; nothing is seen before one
// - stop is SDA rising with SCL high and ends the operation
// - any SDA change with SCL high is a start or stop, never data
// - the receiver of a byte pulls SDA low on the acknowledge clock
// - target address: type code, three strap bits, direction bit
// - direction bit 1 selects read, 0 selects write
// - matching address is acknowledged on ninth clock, then operation proceeds
// - floating straps read as zero, so eight devices share a bus
// - write protect high blocks every array write; low allows writes
// - SDA is only pulled low or released, never driven high
// - a new start aborts any transaction and awaits a target address
// - during power-on reset nothing is obeyed; release enters standby
// - standby after power-up, after non-write stop, after write cycle ends
// - array of 65536 bytes in pages of 128 bytes
// - programming is self timed, at most 5 ms, busy clears itself
// - programming starts at stop; no response until it finishes
// - page write increments low seven address bits, wrapping in page
// - while busy, write address is not acknowledged; acknowledged after
// - reads advance address by one, wrapping from top to zero
`timescale 1ns/10ps
`include "seeb_regs.svh"

module seeb_front_end #(
    parameter int WR_CYCLES = `SEEB_WR_CYCLES,
    parameter int FILT = `SEEB_FILT_CYCLES
) (
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic scl_in,
    input wire logic sda_in,
    output logic sda_out,
    output logic sda_oe,
    input wire logic strap_address_bit_low,
    input wire logic strap_address_bit_mid,
    input wire logic strap_address_bit_high,
    input wire logic write_protect,
    output logic busy,
    output logic standby
);
    localparam int AW = `SEEB_ADDR_W;
    localparam int PW = `SEEB_PAGE_W;
    localparam int NPG = `SEEB_PAGE_BYTES;

    // ----------------------------------------------------------------
    // input conditioning
    // ----------------------------------------------------------------
    logic scl_f;
    logic sda_f;
    logic scl_p_q;
    logic sda_p_q;
    logic [2:0] strap_m_q;
    logic [2:0] strap_q;
    logic wp_m_q;
    logic wp_q;

    seeb_filter #(.FILT(FILT)) u_scl_filt (
        .clk_sys(clk_sys),
        .rst(rst),
        .pin_in(scl_in),
        .pin_out(scl_f)
    );

    seeb_filter #(.FILT(FILT)) u_sda_filt (
        .clk_sys(clk_sys),
        .rst(rst),
        .pin_in(sda_in),
        .pin_out(sda_f)
    );

    // floating straps and write protect are pulled low on the board side
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            strap_m_q <= 3'h0;
            strap_q <= 3'h0;
            wp_m_q <= 1'b0;
            wp_q <= 1'b0;
            scl_p_q <= 1'b1;
            sda_p_q <= 1'b1;
        end else begin
            strap_m_q <= {strap_address_bit_high, strap_address_bit_mid,
                strap_address_bit_low};
            strap_q <= strap_m_q;
            wp_m_q <= write_protect;
            wp_q <= wp_m_q;
            scl_p_q <= scl_f;
            sda_p_q <= sda_f;
        end
    end

    logic start_det;
    logic stop_det;
    logic scl_rise;
    logic scl_fall;

    // SDA moving while SCL stays high is always a condition, never data
    assign start_det = scl_f && scl_p_q && sda_p_q && !sda_f;
    assign stop_det = scl_f && scl_p_q && !sda_p_q && sda_f;
    assign scl_rise = scl_f && !scl_p_q;
    assign scl_fall = !scl_f && scl_p_q;

    // ----------------------------------------------------------------
    // bus state machine
    // ----------------------------------------------------------------
    seeb_pkg::seeb_state_t st_q;
    logic [3:0] bit_cnt_q;
    logic ack_ph_q;
    logic nack_q;
    logic [7:0] rx_q;
    logic [7:0] tx_q;
    logic [AW-1:0] ptr_q;
    logic [7:0] pbuf [NPG];
    logic [NPG-1:0] pbuf_vld_q;
    logic busy_q;
    logic [AW-1:0] busy_base_q;
    logic [7:0] mem [2**AW];
    logic dev_match;
    logic prog_go;
    logic byte_end;

    assign dev_match = rx_q[`SEEB_TYPE_MSB:`SEEB_TYPE_LSB] == `SEEB_TYPE_CODE
        && rx_q[`SEEB_STRAP_MSB:`SEEB_STRAP_LSB] == strap_q;
    assign byte_end = scl_fall && !ack_ph_q && bit_cnt_q == 4'h8;
    // a dummy write (address only) or a protected write programs nothing
    assign prog_go = stop_det && st_q == seeb_pkg::seeb_st_wdat && |pbuf_vld_q
        && !wp_q && !busy_q;

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            st_q <= seeb_pkg::seeb_st_idle;
            bit_cnt_q <= 4'h0;
            ack_ph_q <= 1'b0;
            nack_q <= 1'b0;
            rx_q <= 8'h00;
            tx_q <= 8'h00;
            ptr_q <= '0;
            pbuf_vld_q <= '0;
            sda_oe <= 1'b0;
        end else if (start_det) begin
            st_q <= seeb_pkg::seeb_st_dev;
            bit_cnt_q <= 4'h0;
            ack_ph_q <= 1'b0;
            sda_oe <= 1'b0;
        end else if (stop_det) begin
            st_q <= seeb_pkg::seeb_st_idle;
            ack_ph_q <= 1'b0;
            sda_oe <= 1'b0;
        end else if (st_q != seeb_pkg::seeb_st_idle && st_q != seeb_pkg::seeb_st_ign) begin
            if (scl_rise) begin
                if (ack_ph_q) begin
                    nack_q <= sda_f; // master's answer to a read byte
                end else if (bit_cnt_q != 4'h8) begin
                    rx_q <= {rx_q[6:0], sda_f};
                    bit_cnt_q <= bit_cnt_q + 4'h1;
                end
            end else if (scl_fall && ack_ph_q) begin
                ack_ph_q <= 1'b0;
                bit_cnt_q <= 4'h0;
                sda_oe <= 1'b0;
                if (st_q == seeb_pkg::seeb_st_rdat) begin
                    if (nack_q) begin
                        st_q <= seeb_pkg::seeb_st_ign;
                    end else begin
                        tx_q <= {mem[ptr_q][6:0], 1'b0};
                        sda_oe <= !mem[ptr_q][7];
                        ptr_q <= ptr_q + 16'h0001;
                    end
                end
                nack_q <= 1'b0;
            end else if (byte_end) begin
                ack_ph_q <= 1'b1;
                sda_oe <= 1'b1;
                unique case (st_q)
                    seeb_pkg::seeb_st_dev: begin
                        if (dev_match && !busy_q) begin
                            st_q <= rx_q[`SEEB_RW_BIT] ? seeb_pkg::seeb_st_rdat
                                : seeb_pkg::seeb_st_ahi;
                        end else begin
                            st_q <= seeb_pkg::seeb_st_ign;
                            ack_ph_q <= 1'b0;
                            sda_oe <= 1'b0;
                        end
                    end
                    seeb_pkg::seeb_st_ahi: begin
                        ptr_q[15:8] <= rx_q;
                        st_q <= seeb_pkg::seeb_st_alo;
                    end
                    seeb_pkg::seeb_st_alo: begin
                        ptr_q[7:0] <= rx_q;
                        pbuf_vld_q <= '0;
                        st_q <= seeb_pkg::seeb_st_wdat;
                    end
                    seeb_pkg::seeb_st_wdat: begin
                        if (!wp_q) begin
                            pbuf_vld_q[ptr_q[PW-1:0]] <= 1'b1;
                        end
                        ptr_q[PW-1:0] <= ptr_q[PW-1:0] + 7'h01;
                    end
                    seeb_pkg::seeb_st_rdat: begin
                        sda_oe <= 1'b0; // master acknowledges a read byte
                    end
                    default: begin
                        sda_oe <= 1'b0;
                    end
                endcase
            end else if (scl_fall && st_q == seeb_pkg::seeb_st_rdat
                && bit_cnt_q != 4'h8) begin
                sda_oe <= !tx_q[7];
                tx_q <= {tx_q[6:0], 1'b0};
            end
        end
    end

    // page data is held apart so the array changes only in the write cycle
    always_ff @(posedge clk_sys) begin
        if (byte_end && st_q == seeb_pkg::seeb_st_wdat && !wp_q) begin
            pbuf[ptr_q[PW-1:0]] <= rx_q;
        end
    end

    // ----------------------------------------------------------------
    // self-timed programming cycle
    // ----------------------------------------------------------------
    logic [17:0] wr_cnt_q;

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            busy_q <= 1'b0;
            wr_cnt_q <= 18'h00000;
            busy_base_q <= '0;
        end else if (prog_go) begin
            busy_q <= 1'b1;
            wr_cnt_q <= 18'h00000;
            busy_base_q <= ptr_q;
        end else if (busy_q) begin
            if (wr_cnt_q == 18'(WR_CYCLES - 1)) begin
                busy_q <= 1'b0;
            end
            wr_cnt_q <= wr_cnt_q + 18'h00001;
        end
    end

    // valid bytes of the page are copied one per cycle at the start of the cycle
    always_ff @(posedge clk_sys) begin
        if (busy_q && wr_cnt_q < 18'(NPG) && pbuf_vld_q[wr_cnt_q[PW-1:0]]) begin
            mem[{busy_base_q[AW-1:PW], wr_cnt_q[PW-1:0]}] <= pbuf[wr_cnt_q[PW-1:0]];
        end
    end

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            busy <= 1'b0;
            standby <= 1'b0;
            sda_out <= 1'b0;
        end else begin
            busy <= busy_q;
            standby <= st_q == seeb_pkg::seeb_st_idle && !busy_q;
            sda_out <= 1'b0;
        end
    end

    // ----------------------------------------------------------------
    // checks
    // ----------------------------------------------------------------
    AST_IDLE_UNTIL_START: assert property (@(posedge clk_sys) disable iff (rst)
        (st_q == seeb_pkg::seeb_st_idle && !start_det) |=> st_q == seeb_pkg::seeb_st_idle)
        else $error("left idle without a start");
    AST_START_ABORTS: assert property (@(posedge clk_sys) disable iff (rst)
        start_det |=> st_q == seeb_pkg::seeb_st_dev && bit_cnt_q == 4'h0 && !sda_oe)
        else $error("start did not restart address phase");
    AST_STOP_ENDS: assert property (@(posedge clk_sys) disable iff (rst)
        (stop_det && !start_det) |=> st_q == seeb_pkg::seeb_st_idle
        ##1 standby == !$past(busy_q))
        else $error("stop did not end operation");
    AST_ACK_NINTH: assert property (@(posedge clk_sys) disable iff (rst)
        (byte_end && st_q == seeb_pkg::seeb_st_dev && dev_match && !busy_q)
        |=> sda_oe && ack_ph_q && bit_cnt_q == 4'h8)
        else $error("matching address not acknowledged");
    AST_BUSY_SILENT: assert property (@(posedge clk_sys) disable iff (rst)
        (byte_end && st_q == seeb_pkg::seeb_st_dev && busy_q)
        |=> !sda_oe && st_q == seeb_pkg::seeb_st_ign)
        else $error("address acknowledged while busy");
    AST_RW_SELECT: assert property (@(posedge clk_sys) disable iff (rst)
        (byte_end && st_q == seeb_pkg::seeb_st_dev && dev_match && !busy_q)
        |=> st_q == ($past(rx_q[0]) ? seeb_pkg::seeb_st_rdat : seeb_pkg::seeb_st_ahi))
        else $error("wrong direction chosen");
    AST_WP_NO_PROGRAM: assert property (@(posedge clk_sys) disable iff (rst)
        (wp_q && !busy_q) |=> !busy_q)
        else $error("programming under write protect");
    AST_BUSY_LENGTH: assert property (@(posedge clk_sys) disable iff (rst)
        $fell(busy_q) |-> $past(wr_cnt_q) == 18'(WR_CYCLES - 1))
        else $error("write cycle length wrong");
    AST_PAGE_WRAP: assert property (@(posedge clk_sys) disable iff (rst)
        (byte_end && st_q == seeb_pkg::seeb_st_wdat && !start_det && !stop_det)
        |=> ptr_q[AW-1:PW] == $past(ptr_q[AW-1:PW])
        && ptr_q[PW-1:0] == $past(ptr_q[PW-1:0]) + 7'h01)
        else $error("page address not wrapped");
    AST_READ_INC: assert property (@(posedge clk_sys) disable iff (rst)
        (scl_fall && ack_ph_q && st_q == seeb_pkg::seeb_st_rdat && !nack_q
        && !start_det && !stop_det) |=> ptr_q == $past(ptr_q) + 16'h0001)
        else $error("read address not advanced");
    AST_OPEN_DRAIN: assert property (@(posedge clk_sys) disable iff (rst)
        sda_oe |-> !sda_out)
        else $error("SDA driven high");

endmodule : seeb_front_end

// ===== dv/seeb_mst.sv
/*
 * Behavioural two-wire bus master driving the front end's bus pins.
 * Assumes the bench resolves SDA with a pull-up; moves at falling clk_sys.
 */
`timescale 1ns/10ps
module seeb_mst #(
    parameter int PH = 8
) (
    input wire logic clk_sys,
    input wire logic sda_bus,
    output logic scl,
    output logic sda_low
);
    // ---------
    // bus steps
    // ---------
    // half bit of PH clocks leaves room for the filtered answer
    initial scl = 1'h1;
    initial sda_low = 1'h0;
    task automatic tick(input int n);
        repeat (n) @(negedge clk_sys);
    endtask : tick
    // lets the bench clock bits without a start first
    task automatic scl_low();
        scl = 1'h0;
    endtask : scl_low
    // from idle, or a repeated start after a low scl
    task automatic start_c();
        tick(2);
        sda_low = 1'h0;
        tick(PH - 2);
        scl = 1'h1;
        tick(PH);
        sda_low = 1'h1;
        tick(PH);
        scl = 1'h0;
    endtask : start_c
    task automatic stop_c();
        tick(2);
        sda_low = 1'h1;
        tick(PH - 2);
        scl = 1'h1;
        tick(PH);
        sda_low = 1'h0;
    endtask : stop_c
    // sda moves only while scl is low
    task automatic bit_x(input logic b, output logic s);
        tick(2);
        sda_low = !b;
        tick(PH - 2);
        scl = 1'h1;
        tick(PH / 2);
        s = sda_bus;
        tick(PH / 2);
        scl = 1'h0;
    endtask : bit_x
    // ninth bit pulled low only when mack is set, asking for another read byte
    task automatic byte_x(input logic [7:0] tx, input logic mack, output logic [7:0] rx,
            output logic ack);
        logic s;
        for (int i = 7; i >= 0; i--) begin
            bit_x(tx[i], s);
            rx[i] = s;
        end
        bit_x(!mack, s);
        ack = !s;
    endtask : byte_x
endmodule : seeb_mst

// ===== dv/seeb_front_end_tb.sv
/*
 * Self-checking bench of the serial EEPROM bus front end.
 * Assumes seeb_mst drives the bus; clk_sys 50 MHz, write cycle shortened.
 */
`timescale 1ns/10ps
`include "seeb_regs.svh"
`define CHK(a, e) begin \
    check_count++; \
    if ((a) !== (e)) begin \
        err_total++; \
        $display("[FAIL] t=%0t got=%h exp=%h", $time, (a), (e)); \
    end \
end
module seeb_front_end_tb;
    localparam int WR = 200;
    localparam logic [3:0] TC = `SEEB_TYPE_CODE;
    // row: strap pins, address byte, acknowledge wanted
    localparam logic [11:0] ROWS [6] = '{
        {3'h0, TC, 3'h0, 1'h0, 1'h1},
        {3'h5, TC, 3'h5, 1'h1, 1'h1},
        {3'h7, TC, 3'h7, 1'h0, 1'h1},
        {3'h5, TC, 3'h3, 1'h0, 1'h0},
        {3'h2, TC, 3'h2, 1'h1, 1'h1},
        {3'h0, 4'h7, 3'h0, 1'h0, 1'h0}
    };
    logic clk_sys = 1'h0;
    logic rst = 1'h1;
    logic [2:0] pins = 3'h0;
    logic write_protect = 1'h0;
    logic scl, sda_low, sda_out, sda_oe, busy, standby, sda_wire;
    int err_total = 0;
    int check_count = 0;
    always #10 clk_sys = ~clk_sys;
    // pull-up: high unless a party pulls it low
    assign sda_wire = !(sda_low | sda_oe);
    always @(negedge clk_sys) `CHK(sda_out, 1'h0)
    seeb_front_end #(.WR_CYCLES(WR), .FILT(`SEEB_FILT_CYCLES)) seeb_front_end_i (
        .clk_sys(clk_sys),
        .rst(rst),
        .scl_in(scl),
        .sda_in(sda_wire),
        .sda_out(sda_out),
        .sda_oe(sda_oe),
        .strap_address_bit_low(pins[0]),
        .strap_address_bit_mid(pins[1]),
        .strap_address_bit_high(pins[2]),
        .write_protect(write_protect),
        .busy(busy),
        .standby(standby)
    );
    seeb_mst seeb_mst_i (
        .clk_sys(clk_sys),
        .sda_bus(sda_wire),
        .scl(scl),
        .sda_low(sda_low)
    );
    task automatic summarize();
        $display("checks=%0d errors=%0d", check_count, err_total);
        if (err_total == 0 && check_count > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask : summarize
    task automatic wait_busy(input logic lvl, input int lim);
        int n;
        n = 0;
        while (busy !== lvl) begin
            seeb_mst_i.tick(1);
            n++;
            if (n > lim) begin
                err_total++;
                summarize();
            end
        end
    endtask : wait_busy
    function automatic logic [7:0] devb(input logic rw);
        return {TC, pins, rw};
    endfunction : devb
    task automatic sb(input logic [7:0] b, input logic e);
        logic [7:0] rx;
        logic ack;
        seeb_mst_i.byte_x(b, 1'h0, rx, ack);
        `CHK(ack, e)
    endtask : sb
    task automatic addr_phase(input logic [15:0] a);
        seeb_mst_i.start_c();
        sb(devb(1'h0), 1'h1);
        sb(a[15:8], 1'h1);
        sb(a[7:0], 1'h1);
    endtask : addr_phase
    task automatic wr(input logic [15:0] a, input logic [7:0] d0, input int n);
        addr_phase(a);
        for (int i = 0; i < n; i++) begin
            sb(d0 + i[7:0], 1'h1);
        end
        seeb_mst_i.stop_c();
    endtask : wr
    task automatic rd(input logic [15:0] a, input int n, input logic [23:0] want);
        logic [7:0] rx;
        logic ack;
        addr_phase(a);
        seeb_mst_i.start_c();
        sb(devb(1'h1), 1'h1);
        for (int i = 0; i < n; i++) begin
            seeb_mst_i.byte_x(8'hff, i < n - 1, rx, ack);
            `CHK(rx, want[8 * (n - 1 - i) +: 8])
        end
        seeb_mst_i.stop_c();
    endtask : rd
    // polls are refused while programming; the length is bounded
    task automatic finish_wr();
        realtime t0;
        wait_busy(1'h1, 20);
        t0 = $realtime;
        `CHK(standby, 1'h0)
        seeb_mst_i.start_c();
        sb(devb(1'h0), 1'h0);
        seeb_mst_i.stop_c();
        wait_busy(1'h0, WR);
        `CHK($realtime - t0 <= WR * 20, 1'h1)
        seeb_mst_i.tick(2);
        `CHK(standby, 1'h1)
    endtask : finish_wr
    initial begin
        logic [7:0] rx;
        logic ack;
        logic s;
        logic [7:0] nxt;
        seeb_mst_i.tick(4);
        `CHK({sda_oe, busy, standby}, 3'h0)
        seeb_mst_i.tick(4);
        rst = 1'h0;
        seeb_mst_i.tick(2);
        `CHK(standby, 1'h1)
        seeb_mst_i.tick(8);
        // a byte clocked without any start stays unanswered
        seeb_mst_i.scl_low();
        sb(devb(1'h0), 1'h0);
        seeb_mst_i.stop_c();
        seeb_mst_i.tick(8);
        wr(16'h127e, 8'ha1, 3);
        finish_wr();
        rd(16'h127e, 2, 24'h00a1a2);
        rd(16'h1200, 1, 24'h0000a3);
        wr(16'hffff, 8'hc3, 1);
        finish_wr();
        // four bytes so that later current-address reads meet known data
        wr(16'h0000, 8'h96, 4);
        finish_wr();
        write_protect = 1'h1;
        seeb_mst_i.tick(8);
        wr(16'h0000, 8'h11, 1);
        seeb_mst_i.tick(20);
        `CHK(busy, 1'h0)
        write_protect = 1'h0;
        seeb_mst_i.tick(8);
        rd(16'hffff, 2, 24'h00c396);
        // the pointer now rests at 16'h0001; read rows continue from there
        nxt = 8'h97;
        for (int k = 0; k < 6; k++) begin
            pins = ROWS[k][11:9];
            seeb_mst_i.tick(8);
            seeb_mst_i.start_c();
            seeb_mst_i.byte_x(ROWS[k][8:1], 1'h0, rx, ack);
            `CHK(ack, ROWS[k][0])
            if (ack === 1'h1 && ROWS[k][1]) begin
                seeb_mst_i.byte_x(8'hff, 1'h0, rx, ack);
                `CHK(rx, nxt)
                nxt++;
            end
            seeb_mst_i.stop_c();
            seeb_mst_i.tick(12);
            `CHK(standby, 1'h1)
        end
        pins = 3'h0;
        seeb_mst_i.tick(8);
        // abandon a read after its address, nine clocks free the bus, address again
        seeb_mst_i.start_c();
        sb(devb(1'h1), 1'h1);
        repeat (9) seeb_mst_i.bit_x(1'h1, s);
        `CHK(s, 1'h1)
        seeb_mst_i.start_c();
        sb(devb(1'h0), 1'h1);
        seeb_mst_i.stop_c();
        summarize();
    end
endmodule : seeb_front_end_tb
